//--- clock_select_pkg.sv
// constants for the radio and system clock selection block
package clock_select_pkg;
	localparam int          ADDR_W            = 32;
	localparam int          DATA_W            = 16;
	// register offsets
	localparam logic [31:0] RADIO_CLOCK_OFS   = 32'h0500_0008;
	localparam logic [31:0] SYSTEM_CLOCK_OFS  = 32'h0500_000a;
	localparam logic [31:0] TIMER_CLOCK_OFS   = 32'h0500_000c;
	localparam logic [31:0] LINK_POWER_OFS    = 32'h0500_000e;
	// writable bits per register, reserved and read-only bits excluded
	localparam logic [15:0] RADIO_RW_MASK     = 16'h00fb;
	localparam logic [15:0] SYSTEM_RW_MASK    = 16'h037f;
	localparam logic [15:0] TIMER_RW_MASK     = 16'h7c00;
	localparam logic [15:0] POWER_RW_MASK     = 16'h0004;
	// reset values
	localparam logic [15:0] RADIO_RESET       = 16'h0040;
	localparam logic [15:0] SYSTEM_RESET      = 16'h0001;
	localparam logic [15:0] TIMER_RESET       = 16'h0000;
	localparam logic [15:0] POWER_RESET       = 16'h0004;
	localparam logic [3:0]  STATUS_RESET      = 4'h2;
	// radio clock control fields
	localparam int          LINK_EN_BIT       = 7;
	localparam int          LINK_LP_RST_BIT   = 6;
	localparam int          LINK_DIV_LSB      = 4;
	localparam int          RF_EN_BIT         = 3;
	localparam int          RF_DIV_LSB        = 0;
	// system clock control fields
	localparam int          STATUS_LSB        = 12;
	localparam int          LP_SRC_LSB        = 8;
	localparam int          REF_HALVE_BIT     = 6;
	localparam int          PLL_HALVE_BIT     = 5;
	localparam int          USB_SRC_BIT       = 4;
	localparam int          XTAL_PLLDIV_BIT   = 3;
	localparam int          XTAL_OFF_BIT      = 2;
	localparam int          SYS_SRC_LSB       = 0;
	// timer clock control fields
	localparam int          PWM_MAP_BIT       = 14;
	localparam int          WAKEUP_EN_BIT     = 13;
	localparam int          BREATH_EN_BIT     = 12;
	localparam int          TMR2_SRC_BIT      = 11;
	localparam int          TMR2_EN_BIT       = 10;
	// own power register field
	localparam int          LINK_PD_BIT       = 2;
	// system clock source codes
	localparam logic [1:0]  SRC_CRYSTAL       = 2'h0;
	localparam logic [1:0]  SRC_RC            = 2'h1;
	localparam logic [1:0]  SRC_LOWPOWER      = 2'h2;
	localparam logic [1:0]  SRC_PLL           = 2'h3;
	// status flag layout inside the 4-bit status field
	localparam int          FLAG_SLOW         = 0;
	localparam int          FLAG_RC           = 1;
	localparam int          FLAG_CRYSTAL      = 2;
	localparam int          FLAG_PLL          = 3;
	localparam int          DIV_CNT_W         = 3;
endpackage

//--- clock_tick_divider.sv
// divides a source tick by 1, 2, 4 or 8 and gates it
`timescale 1ns/1ps
`default_nettype none
module clock_tick_divider #(
	parameter int CNT_W = 3
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// control
	input  wire logic       src_tick,
	input  wire logic       en,
	input  wire logic [1:0] div_code,
	// divided tick
	output logic            tick_q
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] mask;
	logic             tick_d;

	assign mask   = CNT_W'((1 << div_code) - 1);
	assign tick_d = en && src_tick && ((cnt_q & mask) == mask);
	// counter parks at zero while gated so the first tick has a fixed phase
	assign cnt_d  = !en ? '0 : (src_tick ? CNT_W'(cnt_q + 1'b1) : cnt_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end
endmodule
`default_nettype wire

//--- radio_system_clock_select.sv
// radio link core, rf unit and system clock selection registers and gating
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - bit 7 enables link core clocks; low keeps them stopped, reset low
// - access to stopped link core raises a hard fault
// - bit 6 holds link low-power timer in reset, resets to one
// - bits 5:4 divide reference by 1, 2, 4 or 8 for link core
// - bit 3 gates the rf control unit clock, reset off
// - bits 1:0 divide rf control unit clock by 1, 2, 4 or 8
// - status bits 15:12 show running source; only rc set at reset
// - bits 9:8 select low-power clock source
// - bit 6 halves the divided crystal reference for a fast crystal
// - bit 5 halves the pll output before any use
// - bit 4 selects usb clock: pll half or ahb clock
// - bit 3 enables crystal dividers feeding both plls
// - bit 2 stops the crystal oscillator two cycles after the write, with no handshake
// - bits 1:0 select system clock source, reset to rc
// - bit 14 maps timer-1 pwm to pad when debugger off, kept in sleep
// - bit 11 selects timer-2 clock: divided reference when clear, undivided when set
// - powerdown bit, set at reset, stops link core system clock
module radio_system_clock_select
	import clock_select_pkg::*;
(
	// clock and reset
	input  wire logic                             clk,
	input  wire logic                             rst,
	// register port
	input  wire logic [clock_select_pkg::ADDR_W-1:0] addr,
	input  wire logic [clock_select_pkg::DATA_W-1:0] wdata,
	input  wire logic                             wr_en,
	input  wire logic                             rd_en,
	output logic [clock_select_pkg::DATA_W-1:0]   rdata_q,
	// system side inputs
	input  wire logic                             link_reg_access,
	input  wire logic                             debugger_en,
	// link core and rf control unit clocks
	output logic                                  link_core_tick_q,
	output logic                                  link_lowpower_timer_reset_q,
	output logic                                  rf_ctrl_unit_tick_q,
	output logic                                  hard_fault_q,
	// oscillator and source controls
	output logic [1:0]                            system_clock_source_q,
	output logic [1:0]                            lowpower_clock_source_q,
	output logic                                  ref_halve_for_fast_crystal_q,
	output logic                                  pll_halve_q,
	output logic                                  usb_clock_source_q,
	output logic                                  crystal_pll_divider_en_q,
	output logic                                  crystal_osc_off_q,
	output logic                                  pll_hold_on_q,
	// timer clocks and pad mapping
	output logic                                  timer1_pwm_pad_map_q,
	output logic                                  wakeup_counter_clock_en_q,
	output logic                                  breathing_led_clock_en_q,
	output logic                                  timer2_tick_q
);
	import clock_select_pkg::*;

	logic [15:0] radio_q;
	logic [15:0] system_q;
	logic [15:0] timer_q;
	logic [15:0] power_q;
	logic [3:0]  status_q;
	logic [3:0]  status_d;
	logic        ref_phase_q;

	// address decode
	wire hit_radio  = (addr == RADIO_CLOCK_OFS);
	wire hit_system = (addr == SYSTEM_CLOCK_OFS);
	wire hit_timer  = (addr == TIMER_CLOCK_OFS);
	wire hit_power  = (addr == LINK_POWER_OFS);
	wire wr_radio   = wr_en && hit_radio;
	wire wr_system  = wr_en && hit_system;
	wire wr_timer   = wr_en && hit_timer;
	wire wr_power   = wr_en && hit_power;

	wire [15:0] system_view = {status_q, system_q[11:0]};
	wire [15:0] rd_mux      = hit_radio  ? radio_q :
	                          hit_system ? system_view :
	                          hit_timer  ? timer_q :
	                          hit_power  ? power_q : 16'h0000;

	// register storage; only writable bits ever change
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			radio_q  <= RADIO_RESET;
			system_q <= SYSTEM_RESET;
			timer_q  <= TIMER_RESET;
			power_q  <= POWER_RESET;
		end else begin
			if (wr_radio)
				radio_q <= wdata & RADIO_RW_MASK;
			if (wr_system)
				system_q <= wdata & SYSTEM_RW_MASK;
			if (wr_timer)
				timer_q <= wdata & TIMER_RW_MASK;
			if (wr_power)
				power_q <= wdata & POWER_RW_MASK;
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata_q <= 16'h0000;
		else
			rdata_q <= rd_en ? rd_mux : 16'h0000;
	end

	// running-source flags follow the selected source one cycle later
	wire [1:0] sys_src = system_q[SYS_SRC_LSB +: 2];
	always_comb begin
		status_d = 4'h0;
		case (sys_src)
			SRC_CRYSTAL:  status_d[FLAG_CRYSTAL] = 1'b1;
			SRC_RC:       status_d[FLAG_RC]      = 1'b1;
			SRC_LOWPOWER: status_d[FLAG_SLOW]    = 1'b1;
			SRC_PLL:      status_d[FLAG_PLL]     = 1'b1;
			default:      status_d[FLAG_RC]      = 1'b1;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			status_q <= STATUS_RESET;
		else
			status_q <= status_d;
	end

	// divided crystal reference: every cycle, or every other when halved
	wire ref_halve = system_q[REF_HALVE_BIT];
	wire ref_tick  = !ref_halve || ref_phase_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ref_phase_q <= 1'b0;
		else
			ref_phase_q <= ref_halve ? !ref_phase_q : 1'b0;
	end

	// link core runs only when enabled and not powered down
	wire link_stopped = !radio_q[LINK_EN_BIT] || power_q[LINK_PD_BIT];

	clock_tick_divider #(
		.CNT_W (DIV_CNT_W)
	) link_div (
		.clk      (clk),
		.rst      (rst),
		.src_tick (ref_tick),
		.en       (!link_stopped),
		.div_code (radio_q[LINK_DIV_LSB +: 2]),
		.tick_q   (link_core_tick_q)
	);

	clock_tick_divider #(
		.CNT_W (DIV_CNT_W)
	) rf_div (
		.clk      (clk),
		.rst      (rst),
		.src_tick (1'b1),
		.en       (radio_q[RF_EN_BIT]),
		.div_code (radio_q[RF_DIV_LSB +: 2]),
		.tick_q   (rf_ctrl_unit_tick_q)
	);

	// control outputs, each from a flip-flop
	wire timer2_tick_d = timer_q[TMR2_EN_BIT] &&
	                     (timer_q[TMR2_SRC_BIT] || ref_tick);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link_lowpower_timer_reset_q  <= 1'b1;
			hard_fault_q                 <= 1'b0;
			system_clock_source_q        <= SRC_RC;
			lowpower_clock_source_q      <= 2'h0;
			ref_halve_for_fast_crystal_q <= 1'b0;
			pll_halve_q                  <= 1'b0;
			usb_clock_source_q           <= 1'b0;
			crystal_pll_divider_en_q     <= 1'b0;
			crystal_osc_off_q            <= 1'b0;
			pll_hold_on_q                <= 1'b0;
			timer1_pwm_pad_map_q         <= 1'b0;
			wakeup_counter_clock_en_q    <= 1'b0;
			breathing_led_clock_en_q     <= 1'b0;
			timer2_tick_q                <= 1'b0;
		end else begin
			link_lowpower_timer_reset_q  <= radio_q[LINK_LP_RST_BIT];
			hard_fault_q                 <= link_reg_access && link_stopped;
			system_clock_source_q        <= sys_src;
			lowpower_clock_source_q      <= system_q[LP_SRC_LSB +: 2];
			ref_halve_for_fast_crystal_q <= ref_halve;
			pll_halve_q                  <= system_q[PLL_HALVE_BIT];
			usb_clock_source_q           <= system_q[USB_SRC_BIT];
			crystal_pll_divider_en_q     <= system_q[XTAL_PLLDIV_BIT];
			// straight through: no handshake, software must not stop it in use
			crystal_osc_off_q            <= system_q[XTAL_OFF_BIT];
			pll_hold_on_q                <= status_q[FLAG_PLL];
			// the register holds through deep sleep, only debug overrides it
			timer1_pwm_pad_map_q         <= timer_q[PWM_MAP_BIT] && !debugger_en;
			wakeup_counter_clock_en_q    <= timer_q[WAKEUP_EN_BIT];
			breathing_led_clock_en_q     <= timer_q[BREATH_EN_BIT];
			timer2_tick_q                <= timer2_tick_d;
		end
	end

	// helper logic for the checks below
	logic [3:0] quiet_q;
	logic [3:0] rf_gap_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			quiet_q  <= 4'h0;
			rf_gap_q <= 4'h0;
		end else begin
			quiet_q  <= (wr_radio || wr_system || wr_power) ? 4'h0 :
			            (quiet_q == 4'hf ? quiet_q : 4'(quiet_q + 1'b1));
			rf_gap_q <= rf_ctrl_unit_tick_q ? 4'h0 :
			            (rf_gap_q == 4'hf ? rf_gap_q : 4'(rf_gap_q + 1'b1));
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_radio_write(logic [15:0] val);
		wr_radio && (wdata == val);
	endsequence

	sequence s_stopped_two;
		link_stopped [*2];
	endsequence

	chk_link_gate_off: assert property (s_stopped_two |-> !link_core_tick_q)
		else $error("link core tick while clock stopped");

	chk_link_fault: assert property (
		(link_reg_access && link_stopped) |=> hard_fault_q)
		else $error("no hard fault on stopped link core access");

	chk_no_false_fault: assert property (!link_stopped |=> !hard_fault_q)
		else $error("hard fault while link core running");

	chk_lp_reset_follow: assert property (
		s_radio_write(16'h0000) |=> ##1 !link_lowpower_timer_reset_q)
		else $error("low-power timer reset not released");

	chk_link_div_gap: assert property (
		(link_core_tick_q && radio_q[LINK_DIV_LSB +: 2] != 2'h0 && quiet_q >= 4'h3)
		|=> !link_core_tick_q)
		else $error("link divider ticks back to back");

	chk_rf_gate_off: assert property (
		(!radio_q[RF_EN_BIT]) [*2] |-> !rf_ctrl_unit_tick_q)
		else $error("rf unit tick while gated");

	chk_rf_div_eight: assert property (
		(rf_ctrl_unit_tick_q && radio_q[RF_DIV_LSB +: 2] == 2'h3 &&
		 radio_q[RF_EN_BIT] && quiet_q >= 4'ha) |-> rf_gap_q == 4'h7)
		else $error("rf divide by eight period wrong");

	chk_status_pll: assert property (
		(sys_src == SRC_PLL) [*2] |-> status_q == 4'h8 ##1 pll_hold_on_q)
		else $error("pll running flag not shown");

	chk_ref_halve_gap: assert property (
		(ref_halve && quiet_q >= 4'h2 && !wr_system && ref_tick) |=> !ref_tick)
		else $error("halved reference ticks back to back");

	chk_crystal_stop: assert property (
		(wr_system && wdata[XTAL_OFF_BIT]) |=> ##1 crystal_osc_off_q)
		else $error("crystal not stopped after write");

	chk_pwm_debug: assert property (debugger_en |=> !timer1_pwm_pad_map_q)
		else $error("pwm mapped to pad with debugger on");

	chk_timer2_gate: assert property (
		(!timer_q[TMR2_EN_BIT]) |=> !timer2_tick_q)
		else $error("timer-2 tick while gated");
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the radio and system clock selection block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import clock_select_pkg::*;
	typedef struct packed {
		logic [31:0] a;
		logic [15:0] w;
		logic [15:0] e;
	} row_t;
	logic        clk, rst, wr_en, rd_en, link_reg_access, debugger_en;
	logic [31:0] addr;
	logic [15:0] wdata, rdata_q, sh_r, sh_s, sh_t, d;
	logic        lk_t, lpr, rf_t, hf, ref_h, pll_h, usb, xdiv, xoff, pll_on, pwm, wk, br, t2_t;
	logic [1:0]  sys_src, lp_src;
	logic [12:0] ctl_seen;
	int          bad_count, n_compared, c_lk, c_rf, c_t2;
	row_t        rows [14];
	radio_system_clock_select dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .link_reg_access(link_reg_access),
		.debugger_en(debugger_en), .link_core_tick_q(lk_t), .link_lowpower_timer_reset_q(lpr),
		.rf_ctrl_unit_tick_q(rf_t), .hard_fault_q(hf), .system_clock_source_q(sys_src),
		.lowpower_clock_source_q(lp_src), .ref_halve_for_fast_crystal_q(ref_h),
		.pll_halve_q(pll_h), .usb_clock_source_q(usb), .crystal_pll_divider_en_q(xdiv),
		.crystal_osc_off_q(xoff), .pll_hold_on_q(pll_on), .timer1_pwm_pad_map_q(pwm),
		.wakeup_counter_clock_en_q(wk), .breathing_led_clock_en_q(br), .timer2_tick_q(t2_t));
	assign ctl_seen = {ref_h, pll_h, usb, xdiv, xoff, lp_src, sys_src, lpr, pwm, wk, br};
	function automatic logic [12:0] ctl_exp(input logic [15:0] s, r, t, input logic dbg);
		return {s[REF_HALVE_BIT], s[PLL_HALVE_BIT], s[USB_SRC_BIT], s[XTAL_PLLDIV_BIT],
			s[XTAL_OFF_BIT], s[9:8], s[1:0], r[LINK_LP_RST_BIT], t[PWM_MAP_BIT] & ~dbg,
			t[WAKEUP_EN_BIT], t[BREATH_EN_BIT]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic wr(input logic [31:0] a, input logic [15:0] w);
		@(posedge clk);
		addr  <= a;
		wdata <= w;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [15:0] v);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata_q;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// counts ticks of the three divided clocks over a 64-cycle window
	task automatic measure();
		c_lk = 0;
		c_rf = 0;
		c_t2 = 0;
		idle(4);
		repeat (64) begin
			@(posedge clk);
			#1;
			c_lk += int'(lk_t === 1'b1);
			c_rf += int'(rf_t === 1'b1);
			c_t2 += int'(t2_t === 1'b1);
		end
	endtask
	// phase of a restarted counter may shift the count by one
	task automatic near(input int n, input int e);
		check(16'(n >= e - 1 && n <= e + 1), 16'h0001);
	endtask
	task automatic fault_probe(input logic exp);
		@(posedge clk);
		link_reg_access <= 1'b1;
		@(posedge clk);
		link_reg_access <= 1'b0;
		#1 check(16'(hf), 16'(exp));
		idle(1);
		check(16'(hf), 16'h0000);
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		bad_count++;
		end_of_test();
	end
	initial begin
		rows[0]  = '{SYSTEM_CLOCK_OFS, 16'h0000, 16'h4000};
		rows[1]  = '{SYSTEM_CLOCK_OFS, 16'h0002, 16'h1002};
		rows[2]  = '{SYSTEM_CLOCK_OFS, 16'h0003, 16'h8003};
		rows[3]  = '{SYSTEM_CLOCK_OFS, 16'h0101, 16'h2101};
		rows[4]  = '{SYSTEM_CLOCK_OFS, 16'h0201, 16'h2201};
		rows[5]  = '{SYSTEM_CLOCK_OFS, 16'hffff, 16'h837f};
		rows[6]  = '{SYSTEM_CLOCK_OFS, 16'h0001, 16'h2001};
		rows[7]  = '{RADIO_CLOCK_OFS, 16'hffff, 16'h00fb};
		rows[8]  = '{RADIO_CLOCK_OFS, 16'h0000, 16'h0000};
		rows[9]  = '{TIMER_CLOCK_OFS, 16'hffff, 16'h7c00};
		rows[10] = '{TIMER_CLOCK_OFS, 16'h0000, 16'h0000};
		rows[11] = '{LINK_POWER_OFS, 16'h0000, 16'h0000};
		rows[12] = '{LINK_POWER_OFS, 16'hffff, 16'h0004};
		rows[13] = '{32'h0500_0006, 16'hffff, 16'h0000};
		bad_count = 0;
		n_compared = 0;
		rst = 1'b1;
		addr = '0;
		wdata = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		link_reg_access = 1'b0;
		debugger_en = 1'b0;
		sh_r = RADIO_RESET;
		sh_s = SYSTEM_RESET;
		sh_t = TIMER_RESET;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1 check(16'({lpr, sys_src, lk_t, rf_t, hf}), 16'h0028);
		rd(RADIO_CLOCK_OFS, d);
		check(d, 16'h0040);
		rd(SYSTEM_CLOCK_OFS, d);
		check(d, 16'h2001);
		rd(TIMER_CLOCK_OFS, d);
		check(d, 16'h0000);
		rd(LINK_POWER_OFS, d);
		check(d, POWER_RESET);
		fault_probe(1'b1);
		for (int i = 0; i < 14; i++) begin
			wr(rows[i].a, rows[i].w);
			idle(2);
			rd(rows[i].a, d);
			check(d, rows[i].e);
			if (rows[i].a == RADIO_CLOCK_OFS) sh_r = rows[i].e;
			if (rows[i].a == SYSTEM_CLOCK_OFS) sh_s = rows[i].e;
			if (rows[i].a == TIMER_CLOCK_OFS) sh_t = rows[i].e;
			check(16'(ctl_seen), 16'(ctl_exp(sh_s, sh_r, sh_t, debugger_en)));
			check(16'(pll_on), 16'(sh_s[15]));
		end
		// pad mapping follows the debugger state
		wr(TIMER_CLOCK_OFS, 16'h4000);
		sh_t = 16'h4000;
		idle(2);
		check(16'(pwm), 16'h0001);
		@(posedge clk) debugger_en <= 1'b1;
		idle(3);
		check(16'(ctl_seen), 16'(ctl_exp(sh_s, sh_r, sh_t, 1'b1)));
		@(posedge clk) debugger_en <= 1'b0;
		// powerdown alone stops the link core
		wr(RADIO_CLOCK_OFS, 16'h0080);
		measure();
		check(16'(c_lk), 16'h0000);
		fault_probe(1'b1);
		wr(LINK_POWER_OFS, 16'h0000);
		fault_probe(1'b0);
		wr(TIMER_CLOCK_OFS, 16'h0c00);
		for (int k = 0; k < 4; k++) begin
			wr(RADIO_CLOCK_OFS, 16'h0088 | 16'(k << 4) | 16'(k));
			measure();
			near(c_lk, 64 >> k);
			near(c_rf, 64 >> k);
			near(c_t2, 64);
		end
		wr(RADIO_CLOCK_OFS, 16'h0088);
		wr(SYSTEM_CLOCK_OFS, 16'h0041);
		wr(TIMER_CLOCK_OFS, 16'h0400);
		measure();
		near(c_lk, 32);
		near(c_t2, 32);
		wr(TIMER_CLOCK_OFS, 16'h0000);
		wr(RADIO_CLOCK_OFS, 16'h0030);
		measure();
		check(16'({c_lk[7:0], c_rf[3:0], c_t2[3:0]}), 16'h0000);
		fault_probe(1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
